// >>> src/tasm_pkg.sv
// Constants shared by the thermal alarm status and mask block.
package tasm_pkg;

  // ----------------------------------------------------------------
  // Register command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_FIRST = 8'h08;
  localparam logic [7:0] ADDR_STATUS_SECOND = 8'h09;
  localparam logic [7:0] ADDR_STATUS_THIRD = 8'h0A;
  localparam logic [7:0] ADDR_MASK_FIRST = 8'h0C;
  localparam logic [7:0] ADDR_MASK_SECOND = 8'h0D;
  localparam logic [7:0] ADDR_MASK_THIRD = 8'h0E;
  localparam logic [7:0] ADDR_HYST = 8'h21;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h30;
  localparam logic [7:0] ADDR_LIM_LOCAL = 8'h40;
  localparam logic [7:0] ADDR_LIM_A_FIRST = 8'h41;
  localparam logic [7:0] ADDR_LIM_B_FIRST = 8'h42;
  localparam logic [7:0] ADDR_LIM_A_SECOND = 8'h49;
  localparam logic [7:0] ADDR_LIM_B_SECOND = 8'h4A;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CH_LOCAL = 0;
  localparam int CH_REMOTE_A = 1;
  localparam int CH_REMOTE_B = 2;
  localparam int NUM_CH = 3;
  localparam int LOCAL_LIM_W = 7;
  localparam logic [2:0] RST_MASK_FIRST = 3'h1;
  localparam logic [2:0] RST_MASK_SECOND = 3'h0;
  localparam logic [2:0] RST_MASK_THIRD = 3'h7;
  localparam logic [6:0] RST_LIM_LOCAL = 7'h55;
  localparam logic [7:0] RST_LIM_REMOTE_FIRST = 8'h6E;
  localparam logic [7:0] RST_LIM_REMOTE_SECOND = 8'h55;
  localparam logic [7:0] RST_HYST = 8'h0A;
  localparam logic [7:0] READ_ZERO = 8'h00;

endpackage : tasm_pkg

// >>> src/tasm_cmp_if.sv
// Bundle between the top and one channel's hysteresis comparator.
`timescale 1ns/100ps
interface tasm_cmp_if;
  logic [7:0] reading;
  logic [7:0] lim_first;
  logic [7:0] lim_second;
  logic [7:0] hyst;
  logic update;
  logic alarm_first;
  logic alarm_second;

  modport cmp (
    input reading,
    input lim_first,
    input lim_second,
    input hyst,
    input update,
    output alarm_first,
    output alarm_second
  );

  modport top (
    output reading,
    output lim_first,
    output lim_second,
    output hyst,
    output update,
    input alarm_first,
    input alarm_second
  );
endinterface : tasm_cmp_if

// >>> src/tasm_chan_cmp.sv
// One channel's two hysteresis alarm bits, one per limit level.
`timescale 1ns/100ps
module tasm_chan_cmp (
  input wire logic clock_in,
  input wire logic rst_b_in,
  tasm_cmp_if.cmp bus
);
  import tasm_pkg::*;

  logic alarm_first_r;
  logic alarm_first_nxt;
  logic alarm_second_r;
  logic alarm_second_nxt;

  // ----------------------------------------------------------------
  // Threshold decision
  // ----------------------------------------------------------------
  // A widened subtraction keeps a limit below the hysteresis from wrapping:
  // then the bit can never clear, which is the safe direction.
  function automatic logic hys_next(input logic cur, input logic [7:0] rd,
                                    input logic [7:0] lim, input logic [7:0] hy);
    logic [8:0] low;
    low = {1'b0, lim} - {1'b0, hy};
    if (rd >= lim)
      hys_next = 1'b1;
    else if (!low[8] && ({1'b0, rd} < low))
      hys_next = 1'b0;
    else
      hys_next = cur;
  endfunction : hys_next

  always_comb
  begin
    alarm_first_nxt = alarm_first_r;
    alarm_second_nxt = alarm_second_r;
    if (bus.update)
    begin
      alarm_first_nxt = hys_next(alarm_first_r, bus.reading, bus.lim_first, bus.hyst);
      alarm_second_nxt = hys_next(alarm_second_r, bus.reading, bus.lim_second, bus.hyst);
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      alarm_first_r <= 1'b0;
      alarm_second_r <= 1'b0;
    end
    else
    begin
      alarm_first_r <= alarm_first_nxt;
      alarm_second_r <= alarm_second_nxt;
    end
  end

  assign bus.alarm_first = alarm_first_r;
  assign bus.alarm_second = alarm_second_r;

endmodule : tasm_chan_cmp

// >>> src/tasm_top.sv
// Alarm status, mask and critical output logic for a three-channel sensor.
`timescale 1ns/100ps
module tasm_top #(
  parameter int TEMP_W = 8
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [TEMP_W-1:0] local_temp_in,
  input wire logic [TEMP_W-1:0] remote_a_temp_in,
  input wire logic [TEMP_W-1:0] remote_b_temp_in,
  input wire logic [tasm_pkg::NUM_CH-1:0] conv_done_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [2:0] crit_pin_in,
  output logic [2:0] crit_pin_out,
  output logic [2:0] crit_pin_oe_out
);
  import tasm_pkg::*;

  // The comparators and the register map are built for byte-wide readings.
  if (TEMP_W != 8)
  begin : g_bad_width
    $error("tasm_top supports only 8-bit readings");
  end

  // ----------------------------------------------------------------
  // Writable registers, internal state and channel wiring
  // ----------------------------------------------------------------
  logic [2:0] mask_first_r, mask_first_nxt;
  logic [2:0] mask_second_r, mask_second_nxt;
  logic [2:0] mask_third_r, mask_third_nxt;
  logic [6:0] lim_local_r, lim_local_nxt;
  logic [7:0] lim_a_first_r, lim_a_first_nxt;
  logic [7:0] lim_b_first_r, lim_b_first_nxt;
  logic [7:0] lim_a_second_r, lim_a_second_nxt;
  logic [7:0] lim_b_second_r, lim_b_second_nxt;
  logic [7:0] hyst_r, hyst_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [2:0] crit_oe_r, crit_oe_nxt;
  logic [2:0] drive_lvl_r, drive_lvl_nxt;
  logic [2:0] pin_meta_r, pin_sync_r;

  logic [2:0] status_first, status_second, status_third;
  logic [7:0] readings [NUM_CH];
  logic [7:0] lims_first [NUM_CH];
  logic [7:0] lims_second [NUM_CH];

  assign readings[CH_LOCAL] = local_temp_in;
  assign readings[CH_REMOTE_A] = remote_a_temp_in;
  assign readings[CH_REMOTE_B] = remote_b_temp_in;
  assign lims_first[CH_LOCAL] = {1'b0, lim_local_r};
  assign lims_first[CH_REMOTE_A] = lim_a_first_r;
  assign lims_first[CH_REMOTE_B] = lim_b_first_r;
  assign lims_second[CH_LOCAL] = {1'b0, lim_local_r};
  assign lims_second[CH_REMOTE_A] = lim_a_second_r;
  assign lims_second[CH_REMOTE_B] = lim_b_second_r;

  // ----------------------------------------------------------------
  // Per-channel comparators
  // ----------------------------------------------------------------
  // The local channel has one limit for every output, so its first and
  // second bits always agree; the third status mirrors the second.
  generate
    for (genvar ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      tasm_cmp_if cbus ();
      assign cbus.reading = readings[ch];
      assign cbus.lim_first = lims_first[ch];
      assign cbus.lim_second = lims_second[ch];
      assign cbus.hyst = hyst_r;
      assign cbus.update = conv_done_in[ch];
      assign status_first[ch] = cbus.alarm_first;
      assign status_second[ch] = cbus.alarm_second;
      assign status_third[ch] = cbus.alarm_second;
      tasm_chan_cmp u_cmp (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .bus(cbus)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register writes and reads
  // ----------------------------------------------------------------
  always_comb
  begin
    mask_first_nxt = mask_first_r;
    mask_second_nxt = mask_second_r;
    mask_third_nxt = mask_third_r;
    lim_local_nxt = lim_local_r;
    lim_a_first_nxt = lim_a_first_r;
    lim_b_first_nxt = lim_b_first_r;
    lim_a_second_nxt = lim_a_second_r;
    lim_b_second_nxt = lim_b_second_r;
    hyst_nxt = hyst_r;
    // Status addresses fall through untouched.
    if (reg_wr_in)
    begin
      if (reg_addr_in == ADDR_MASK_FIRST)
        mask_first_nxt = reg_wdata_in[2:0];
      else if (reg_addr_in == ADDR_MASK_SECOND)
        mask_second_nxt = reg_wdata_in[2:0];
      else if (reg_addr_in == ADDR_MASK_THIRD)
        mask_third_nxt = reg_wdata_in[2:0];
      else if (reg_addr_in == ADDR_LIM_LOCAL)
        lim_local_nxt = reg_wdata_in[LOCAL_LIM_W-1:0];
      else if (reg_addr_in == ADDR_LIM_A_FIRST)
        lim_a_first_nxt = reg_wdata_in;
      else if (reg_addr_in == ADDR_LIM_B_FIRST)
        lim_b_first_nxt = reg_wdata_in;
      else if (reg_addr_in == ADDR_LIM_A_SECOND)
        lim_a_second_nxt = reg_wdata_in;
      else if (reg_addr_in == ADDR_LIM_B_SECOND)
        lim_b_second_nxt = reg_wdata_in;
      else if (reg_addr_in == ADDR_HYST)
        hyst_nxt = reg_wdata_in;
    end
  end

  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_rd_in)
    begin
      if (reg_addr_in == ADDR_STATUS_FIRST)
        rdata_nxt = {5'h00, status_first};
      else if (reg_addr_in == ADDR_STATUS_SECOND)
        rdata_nxt = {5'h00, status_second};
      else if (reg_addr_in == ADDR_STATUS_THIRD)
        rdata_nxt = {5'h00, status_third};
      else if (reg_addr_in == ADDR_MASK_FIRST)
        rdata_nxt = {5'h00, mask_first_r};
      else if (reg_addr_in == ADDR_MASK_SECOND)
        rdata_nxt = {5'h00, mask_second_r};
      else if (reg_addr_in == ADDR_MASK_THIRD)
        rdata_nxt = {5'h00, mask_third_r};
      else if (reg_addr_in == ADDR_LIM_LOCAL)
        rdata_nxt = {1'b0, lim_local_r};
      else if (reg_addr_in == ADDR_LIM_A_FIRST)
        rdata_nxt = lim_a_first_r;
      else if (reg_addr_in == ADDR_LIM_B_FIRST)
        rdata_nxt = lim_b_first_r;
      else if (reg_addr_in == ADDR_LIM_A_SECOND)
        rdata_nxt = lim_a_second_r;
      else if (reg_addr_in == ADDR_LIM_B_SECOND)
        rdata_nxt = lim_b_second_r;
      else if (reg_addr_in == ADDR_HYST)
        rdata_nxt = hyst_r;
      else if (reg_addr_in == ADDR_PIN_LEVEL)
        rdata_nxt = {5'h00, pin_sync_r};
      else
        rdata_nxt = READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Critical outputs
  // ----------------------------------------------------------------
  // The pins are open-drain and active low: asserting means enabling a
  // driven low level.
  always_comb
  begin
    crit_oe_nxt[0] = |(status_first & ~mask_first_r);
    crit_oe_nxt[1] = |(status_second & ~mask_second_r);
    crit_oe_nxt[2] = |(status_third & ~mask_third_r);
    drive_lvl_nxt = 3'h0;
  end

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mask_first_r <= RST_MASK_FIRST;
      mask_second_r <= RST_MASK_SECOND;
      mask_third_r <= RST_MASK_THIRD;
      lim_local_r <= RST_LIM_LOCAL;
      lim_a_first_r <= RST_LIM_REMOTE_FIRST;
      lim_b_first_r <= RST_LIM_REMOTE_FIRST;
      lim_a_second_r <= RST_LIM_REMOTE_SECOND;
      lim_b_second_r <= RST_LIM_REMOTE_SECOND;
      hyst_r <= RST_HYST;
      rdata_r <= READ_ZERO;
      crit_oe_r <= 3'h0;
      drive_lvl_r <= 3'h0;
      pin_meta_r <= 3'h7;
      pin_sync_r <= 3'h7;
    end
    else
    begin
      mask_first_r <= mask_first_nxt;
      mask_second_r <= mask_second_nxt;
      mask_third_r <= mask_third_nxt;
      lim_local_r <= lim_local_nxt;
      lim_a_first_r <= lim_a_first_nxt;
      lim_b_first_r <= lim_b_first_nxt;
      lim_a_second_r <= lim_a_second_nxt;
      lim_b_second_r <= lim_b_second_nxt;
      hyst_r <= hyst_nxt;
      rdata_r <= rdata_nxt;
      crit_oe_r <= crit_oe_nxt;
      drive_lvl_r <= drive_lvl_nxt;
      pin_meta_r <= crit_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign crit_pin_oe_out = crit_oe_r;
  assign crit_pin_out = drive_lvl_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);

  // Unmasked hits of the second and third outputs, one cycle ahead of the pins.
  logic [1:0] hit_chk;
  assign hit_chk = {|(status_third & ~mask_third_r), |(status_second & ~mask_second_r)};

  a_first_out_set: assert property (
      (|(status_first & ~mask_first_r)) |=> crit_pin_oe_out[0])
    else $error("first critical output failed to assert");
  a_first_out_release: assert property (
      !(|(status_first & ~mask_first_r)) |=> !crit_pin_oe_out[0])
    else $error("first critical output failed to release");
  a_second_third_out: assert property (
      crit_pin_oe_out[2:1] == $past(hit_chk))
    else $error("second or third critical output wrong");
  a_local_set: assert property (
      (conv_done_in[0] && local_temp_in >= {1'b0, lim_local_r})
      |=> status_first[0] && status_second[0] && status_third[0])
    else $error("local alarm not set at limit");
  a_local_clear: assert property (
      (conv_done_in[0] && {1'b0, lim_local_r} >= hyst_r &&
      local_temp_in < {1'b0, lim_local_r} - hyst_r)
      |=> !status_first[0] && !status_third[0])
    else $error("local alarm not cleared below hysteresis");
  a_remote_first_set: assert property (
      (conv_done_in[2] && remote_b_temp_in >= lim_b_first_r) |=> status_first[2])
    else $error("remote b first alarm not set");
  a_remote_second_set: assert property (
      (conv_done_in[1] && remote_a_temp_in >= lim_a_second_r)
      |=> status_second[1] && status_third[1])
    else $error("remote a second alarm not set");
  a_remote_clear: assert property (
      (conv_done_in[1] && lim_a_first_r >= hyst_r &&
      remote_a_temp_in < lim_a_first_r - hyst_r) |=> !status_first[1])
    else $error("remote a first alarm not cleared");
  a_status_reserved: assert property (
      (reg_rd_in && reg_addr_in >= ADDR_STATUS_FIRST &&
      reg_addr_in <= ADDR_MASK_THIRD) |=> reg_rdata_out[7:3] == 5'h00)
    else $error("reserved bits read nonzero");
  a_hold_no_conv: assert property (
      !conv_done_in[2] |=> $stable(status_first[2]))
    else $error("alarm bit moved without a conversion");

endmodule : tasm_top

// >>> dv/tasm_host_model.sv
// Host model that reaches the alarm registers over the strobe port.
`timescale 1ns/100ps
module tasm_host_model (
  input wire logic clock_in,
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_rd_out,
  input wire logic [7:0] reg_rdata_in
);
  initial
  begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out = 1'b0;
  end

  // An idle edge follows each strobe, so the next call never reassigns it in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge clock_in);
    #1 reg_wr_out = 1'b0;
    reg_wdata_out = ~d;
    @(posedge clock_in);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge clock_in);
    #1 reg_rd_out = 1'b0;
    d = reg_rdata_in;
    reg_addr_out = ~a;
    @(posedge clock_in);
    #1;
  endtask : rd
endmodule : tasm_host_model

// >>> dv/tb_tasm_top.sv
// Self-checking bench for the thermal alarm status and mask block.
`timescale 1ns/100ps
module tb_tasm_top;
  import tasm_pkg::*;
  logic clock_in;
  logic rst_b_in = 1'b0;
  logic [7:0] t_v [3];
  logic [2:0] conv = 3'h0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd;
  logic [2:0] pin_out, oe, pin_lvl;
  logic [2:0] st1 = 3'h0, st2 = 3'h0, exp_oe;
  logic [2:0] m [3];
  logic [7:0] lim1 [3] = '{8'h40, 8'h60, 8'h62};
  logic [7:0] lim2 [3] = '{8'h40, 8'h50, 8'h52};
  logic [7:0] rst_a [13] = '{8'h0C, 8'h0D, 8'h0E, 8'h40, 8'h41, 8'h42, 8'h49, 8'h4A,
    8'h21, 8'h08, 8'h09, 8'h0A, 8'h7F};
  logic [7:0] rst_v [13] = '{8'h01, 8'h00, 8'h07, 8'h55, 8'h6E, 8'h6E, 8'h55, 8'h55,
    8'h0A, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] cfg_a [12] = '{8'h0C, 8'h0D, 8'h0E, 8'h40, 8'h08, 8'h7F, 8'h40, 8'h41,
    8'h42, 8'h49, 8'h4A, 8'h21};
  logic [7:0] cfg_w [12] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h40, 8'h60,
    8'h62, 8'h50, 8'h52, 8'h08};
  logic [7:0] cfg_r [12] = '{8'h07, 8'h07, 8'h07, 8'h7F, 8'h00, 8'h00, 8'h40, 8'h60,
    8'h62, 8'h50, 8'h52, 8'h08};
  integer seed;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;

  // Open-drain pins with pull-ups: low only while driven.
  assign pin_lvl = (oe & pin_out) | ~oe;

  tasm_top u_tasm_top (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .local_temp_in(t_v[0]),
    .remote_a_temp_in(t_v[1]), .remote_b_temp_in(t_v[2]), .conv_done_in(conv),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .crit_pin_in(pin_lvl), .crit_pin_out(pin_out),
    .crit_pin_oe_out(oe)
  );

  tasm_host_model u_tasm_host_model (
    .clock_in(clock_in), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_wdata_out(wdata), .reg_rd_out(rd), .reg_rdata_in(rdata)
  );

  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Set at the limit, clear below limit minus hysteresis, hold between.
  function automatic logic nx(logic old, int rv, int lim, int hy);
    return (rv >= lim) ? 1'b1 : ((rv + hy < lim) ? 1'b0 : old);
  endfunction : nx

  // ----------------------------------------------------------------
  // One conversion round and its checks
  // ----------------------------------------------------------------
  task automatic step(input logic [7:0] a, b, c, input logic [2:0] cv);
    logic [7:0] v [3];
    v = '{a, b, c};
    t_v = v;
    conv = cv;
    @(posedge clock_in);
    #1 conv = 3'h0;
    t_v = '{~a, ~b, ~c};
    for (int i = 0; i < 3; i++)
      if (cv[i])
      begin
        st1[i] = nx(st1[i], v[i], lim1[i], 8);
        st2[i] = nx(st2[i], v[i], lim2[i], 8);
      end
    repeat (3) @(posedge clock_in);
    #1 exp_oe = {|(st2 & ~m[2]), |(st2 & ~m[1]), |(st1 & ~m[0])};
    check({5'h00, oe}, {5'h00, exp_oe});
    u_tasm_host_model.rd(ADDR_STATUS_FIRST, d);
    check(d, {5'h00, st1});
    u_tasm_host_model.rd(ADDR_STATUS_SECOND, d);
    check(d, {5'h00, st2});
    u_tasm_host_model.rd(ADDR_STATUS_THIRD, d);
    check(d, {5'h00, st2});
    u_tasm_host_model.rd(ADDR_PIN_LEVEL, d);
    check({5'h00, d[2:0]}, {5'h00, ~exp_oe});
  endtask : step

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 13;
    t_v = '{8'h00, 8'h00, 8'h00};
    m = '{3'h0, 3'h0, 3'h0};
    repeat (20) @(posedge clock_in);
    #1 rst_b_in = 1'b1;
    check({5'h00, oe}, 8'h00);
    check({5'h00, pin_out}, 8'h00);
    for (int k = 0; k < 13; k++)
    begin
      u_tasm_host_model.rd(rst_a[k], d);
      check(d, rst_v[k]);
    end
    for (int k = 0; k < 12; k++)
    begin
      u_tasm_host_model.wr(cfg_a[k], cfg_w[k]);
      u_tasm_host_model.rd(cfg_a[k], d);
      check(d, cfg_r[k]);
    end
    for (int k = 0; k < 3; k++)
      u_tasm_host_model.wr(ADDR_MASK_FIRST + k, 8'h00);
    step(8'h40, 8'h60, 8'h52, 3'h7);
    step(8'h38, 8'h58, 8'h4A, 3'h7);
    step(8'h37, 8'h57, 8'h49, 3'h7);
    for (int n = 0; n < 150; n++)
    begin
      for (int k = 0; k < 3; k++)
      begin
        // Random upper bits land in the reserved field and must be dropped.
        m[k] = $random(seed);
        u_tasm_host_model.wr(ADDR_MASK_FIRST + k, ($random(seed) & 32'hFFFF_FFF8) | m[k]);
      end
      step(8'h30 + ($random(seed) & 8'h3F), 8'h30 + ($random(seed) & 8'h3F),
        8'h30 + ($random(seed) & 8'h3F), $random(seed));
    end
    final_report();
  end
endmodule : tb_tasm_top
